// ==== hw/iad_decoder_map.vh ====
`ifndef IAD_DECODER_MAP_VH
`define IAD_DECODER_MAP_VH

// Register byte offsets on the AXI4-Lite slave.
`define IAD_OFS_ACCA 6'h00
`define IAD_OFS_ACCB 6'h04
`define IAD_OFS_DACC 6'h08
`define IAD_OFS_INDEX1 6'h0C
`define IAD_OFS_INDEX2 6'h10
`define IAD_OFS_SP 6'h14
`define IAD_OFS_PC 6'h18
`define IAD_OFS_FLAGS 6'h1C
`define IAD_OFS_CTRL 6'h20
`define IAD_OFS_STATUS 6'h24
`define IAD_OFS_LASTADDR 6'h28

// Reset values.
`define IAD_RST_WORD 16'h0000
`define IAD_RST_FLAGS 8'hD0
`define IAD_RST_CTRL 1'b0

// Flags register bit positions.
`define IAD_FLG_STOPDIS 7
`define IAD_FLG_XMASK 6
`define IAD_FLG_HALF 5
`define IAD_FLG_IMASK 4
`define IAD_FLG_NEG 3
`define IAD_FLG_ZERO 2
`define IAD_FLG_OVF 1
`define IAD_FLG_CARRY 0

// Status register bit positions.
`define IAD_STS_BUSY 0
`define IAD_STS_ILLEGAL 1
`define IAD_STS_MODE_LO 2
`define IAD_STS_MODE_HI 3

// Opcode page prefix and addressing mode field of the opcode.
`define IAD_PAGE2_PREFIX 8'h18
`define IAD_MODE_REL 2'h0
`define IAD_MODE_DIR 2'h1
`define IAD_MODE_IDX 2'h2
`define IAD_MODE_EXT 2'h3

// Base register select codes.
`define IAD_BASE_INDEX1 2'h0
`define IAD_BASE_INDEX2 2'h1
`define IAD_BASE_SP 2'h2
`define IAD_BASE_PC 2'h3

// Stack step for one word.
`define IAD_STACK_STEP 16'h0002

`endif

// ==== hw/iad_indexed_address_decoder.v ====
`timescale 1ns/1ps
`include "iad_decoder_map.vh"

module iad_indexed_address_decoder
(
   input wire clk, // Core bus clock.
   input wire nrst, // Asynchronous active-low reset.
   input wire qValid, // Queue holds the bytes of a new instruction.
   input wire [7:0] qByte0, // Instruction byte at the program counter.
   input wire [7:0] qByte1, // Next instruction byte.
   input wire [7:0] qByte2, // Next instruction byte.
   input wire [7:0] qByte3, // Next instruction byte.
   input wire [7:0] qByte4, // Next instruction byte.
   output reg qReady, // Decoder takes the queue bytes.
   output reg addrValid, // One-cycle pulse with a decoded address.
   output reg [15:0] effAddr, // Effective operand address.
   output reg [2:0] instrLen, // Bytes of the instruction consumed.
   output reg page2, // Opcode came from the second page.
   output reg [7:0] opcode, // Opcode without the prefix.
   output reg illegal, // Decoded form is not legal.
   output reg memReq, // Byte read request for a pointer fetch.
   output reg [15:0] memAddr, // Byte address of the pointer read.
   input wire memAck, // Memory returns the requested byte.
   input wire [7:0] memData, // Byte returned by memory.
   input wire stackPush, // Push one word onto the stack.
   input wire stackPull, // Pull one word from the stack.
   input wire [5:0] s_axi_awaddr, // Write address.
   input wire s_axi_awvalid, // Write address valid.
   output reg s_axi_awready, // Write address ready.
   input wire [31:0] s_axi_wdata, // Write data.
   input wire [3:0] s_axi_wstrb, // Write byte strobes.
   input wire s_axi_wvalid, // Write data valid.
   output reg s_axi_wready, // Write data ready.
   output reg [1:0] s_axi_bresp, // Write response.
   output reg s_axi_bvalid, // Write response valid.
   input wire s_axi_bready, // Write response ready.
   input wire [5:0] s_axi_araddr, // Read address.
   input wire s_axi_arvalid, // Read address valid.
   output reg s_axi_arready, // Read address ready.
   output reg [31:0] s_axi_rdata, // Read data.
   output reg [1:0] s_axi_rresp, // Read response.
   output reg s_axi_rvalid, // Read data valid.
   input wire s_axi_rready // Read data ready.
);

   localparam ST_IDLE = 3'h0;
   localparam ST_CALC = 3'h1;
   localparam ST_PTRHI = 3'h2;
   localparam ST_PTRLO = 3'h3;
   localparam ST_DONE = 3'h4;

   reg rstSync1_reg;
   reg rstSync2_reg;
   wire rstN = rstSync2_reg;

   reg [2:0] state_reg;
   reg [7:0] b0_reg, b1_reg, b2_reg, b3_reg, b4_reg;
   reg [7:0] accA_reg, accB_reg, flags_reg;
   reg [15:0] index1_reg, index2_reg, sp_reg, pc_reg;
   reg ctrlEnable_reg, illegalSticky_reg;
   reg [1:0] lastMode_reg;
   reg [15:0] lastAddr_reg;
   reg [15:0] ptrAddr_reg;
   reg [7:0] ptrHi_reg;
   reg awTaken_reg, wTaken_reg;
   reg [5:0] awAddr_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;

   // Decode results, formed from the latched queue bytes.
   reg pg2;
   reg [7:0] op, o0, o1, o2, pb;
   reg [1:0] mode, baseSel;
   reg [2:0] len;
   reg [15:0] pcNext, base, offset, addr;
   reg indirect, upd, bad;
   reg [15:0] updVal;
   reg [15:0] step;
   wire [15:0] dAcc = {accA_reg, accB_reg};

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstSync1_reg <= 1'b0;
         rstSync2_reg <= 1'b0;
      end
      else
      begin
         rstSync1_reg <= 1'b1;
         rstSync2_reg <= rstSync1_reg;
      end
   end

   always @*
   begin
      pg2 = (b0_reg == `IAD_PAGE2_PREFIX);
      op = pg2 ? b1_reg : b0_reg;
      o0 = pg2 ? b2_reg : b1_reg;
      o1 = pg2 ? b3_reg : b2_reg;
      o2 = pg2 ? b4_reg : b3_reg;
      pb = o0;
      mode = op[5:4];
      baseSel = `IAD_BASE_INDEX1;
      len = pg2 ? 3'h2 : 3'h1;
      offset = 16'h0000;
      indirect = 1'b0;
      upd = 1'b0;
      bad = 1'b0;
      step = 16'h0000;
      case (mode)
         `IAD_MODE_REL:
            len = len + (pg2 ? 3'h2 : 3'h1);
         `IAD_MODE_DIR:
            len = len + 3'h1;
         `IAD_MODE_EXT:
            len = len + 3'h2;
         default:
         begin
            len = len + 3'h1;
            if (!pb[5])
            begin
               baseSel = pb[7:6];
               offset = {{11{pb[4]}}, pb[4:0]};
            end
            else if (pb[7:5] != 3'h7)
            begin
               baseSel = pb[7:6];
               step = pb[3] ? {12'hFFF, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001;
               upd = (pb[7:6] != `IAD_BASE_PC);
               bad = (pb[7:6] == `IAD_BASE_PC);
               offset = pb[4] ? 16'h0000 : step;
            end
            else if (!pb[2])
            begin
               baseSel = pb[4:3];
               if (!pb[1])
               begin
                  offset = {{8{pb[0]}}, o1};
                  len = len + 3'h1;
               end
               else
               begin
                  offset = {o1, o2};
                  len = len + 3'h2;
                  indirect = pb[0];
               end
            end
            else
            begin
               baseSel = pb[4:3];
               case (pb[1:0])
                  2'h0: offset = {8'h00, accA_reg};
                  2'h1: offset = {8'h00, accB_reg};
                  default: offset = dAcc;
               endcase
               indirect = (pb[1:0] == 2'h3);
            end
         end
      endcase
      pcNext = pc_reg + {13'h000, len};
      case (baseSel)
         `IAD_BASE_INDEX1: base = index1_reg;
         `IAD_BASE_INDEX2: base = index2_reg;
         `IAD_BASE_SP: base = sp_reg;
         default: base = pcNext;
      endcase
      updVal = base + step;
      case (mode)
         `IAD_MODE_REL: addr = pcNext + (pg2 ? {o0, o1} : {{8{o0[7]}}, o0});
         `IAD_MODE_DIR: addr = {8'h00, o0};
         `IAD_MODE_EXT: addr = {o0, o1};
         default: addr = base + offset;
      endcase
   end

   // Decoder sequence and register file.
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_reg <= ST_IDLE;
         {b0_reg, b1_reg, b2_reg, b3_reg, b4_reg} <= 40'h0000000000;
         accA_reg <= 8'h00;
         accB_reg <= 8'h00;
         index1_reg <= `IAD_RST_WORD;
         index2_reg <= `IAD_RST_WORD;
         sp_reg <= `IAD_RST_WORD;
         pc_reg <= `IAD_RST_WORD;
         flags_reg <= `IAD_RST_FLAGS;
         ctrlEnable_reg <= `IAD_RST_CTRL;
         illegalSticky_reg <= 1'b0;
         lastMode_reg <= 2'h0;
         lastAddr_reg <= 16'h0000;
         ptrAddr_reg <= 16'h0000;
         ptrHi_reg <= 8'h00;
         qReady <= 1'b0;
         addrValid <= 1'b0;
         effAddr <= 16'h0000;
         instrLen <= 3'h0;
         page2 <= 1'b0;
         opcode <= 8'h00;
         illegal <= 1'b0;
         memReq <= 1'b0;
         memAddr <= 16'h0000;
      end
      else
      begin
         qReady <= 1'b0;
         addrValid <= 1'b0;
         case (state_reg)
            ST_IDLE:
               if (qValid && ctrlEnable_reg && !qReady)
               begin
                  qReady <= 1'b1;
                  {b0_reg, b1_reg, b2_reg, b3_reg, b4_reg} <= {qByte0, qByte1, qByte2, qByte3, qByte4};
                  state_reg <= ST_CALC;
               end
            ST_CALC:
            begin
               pc_reg <= pcNext;
               instrLen <= len;
               page2 <= pg2;
               opcode <= op;
               illegal <= bad;
               lastMode_reg <= mode;
               if (upd)
               begin
                  case (baseSel)
                     `IAD_BASE_INDEX1: index1_reg <= updVal;
                     `IAD_BASE_INDEX2: index2_reg <= updVal;
                     default: sp_reg <= updVal;
                  endcase
               end
               if (mode == `IAD_MODE_IDX && indirect)
               begin
                  ptrAddr_reg <= addr;
                  memAddr <= addr;
                  memReq <= 1'b1;
                  state_reg <= ST_PTRHI;
               end
               else
               begin
                  effAddr <= addr;
                  state_reg <= ST_DONE;
               end
            end
            ST_PTRHI:
               if (memAck)
               begin
                  ptrHi_reg <= memData;
                  memAddr <= ptrAddr_reg + 16'h0001;
                  state_reg <= ST_PTRLO;
               end
            ST_PTRLO:
               if (memAck)
               begin
                  memReq <= 1'b0;
                  effAddr <= {ptrHi_reg, memData};
                  state_reg <= ST_DONE;
               end
            ST_DONE:
            begin
               addrValid <= 1'b1;
               lastAddr_reg <= effAddr;
               state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
         if (state_reg != ST_CALC)
         begin
            if (stackPush && !stackPull)
               sp_reg <= sp_reg - `IAD_STACK_STEP;
            else if (stackPull && !stackPush)
               sp_reg <= sp_reg + `IAD_STACK_STEP;
         end
         if (awTaken_reg && wTaken_reg && !s_axi_bvalid)
         begin
            case (awAddr_reg)
               `IAD_OFS_ACCA: if (wStrb_reg[0]) accA_reg <= wData_reg[7:0];
               `IAD_OFS_ACCB: if (wStrb_reg[0]) accB_reg <= wData_reg[7:0];
               `IAD_OFS_DACC:
               begin
                  if (wStrb_reg[1]) accA_reg <= wData_reg[15:8];
                  if (wStrb_reg[0]) accB_reg <= wData_reg[7:0];
               end
               `IAD_OFS_INDEX1: if (&wStrb_reg[1:0]) index1_reg <= wData_reg[15:0];
               `IAD_OFS_INDEX2: if (&wStrb_reg[1:0]) index2_reg <= wData_reg[15:0];
               `IAD_OFS_SP: if (&wStrb_reg[1:0]) sp_reg <= wData_reg[15:0];
               `IAD_OFS_PC: if (&wStrb_reg[1:0]) pc_reg <= wData_reg[15:0];
               `IAD_OFS_FLAGS: if (wStrb_reg[0]) flags_reg <= wData_reg[7:0];
               `IAD_OFS_CTRL: if (wStrb_reg[0]) ctrlEnable_reg <= wData_reg[0];
               default: ;
            endcase
         end
         // A new illegal decode wins over a clear written in the same cycle.
         if (state_reg == ST_CALC && bad)
            illegalSticky_reg <= 1'b1;
         else if (awTaken_reg && wTaken_reg && !s_axi_bvalid && awAddr_reg == `IAD_OFS_STATUS
            && wStrb_reg[0] && wData_reg[`IAD_STS_ILLEGAL])
            illegalSticky_reg <= 1'b0;
      end
   end

   // AXI4-Lite write channels, address and data taken in either order.
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         awTaken_reg <= 1'b0;
         wTaken_reg <= 1'b0;
         awAddr_reg <= 6'h00;
         wData_reg <= 32'h00000000;
         wStrb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         if (s_axi_awvalid && !awTaken_reg && !s_axi_awready && !s_axi_bvalid)
         begin
            s_axi_awready <= 1'b1;
            awTaken_reg <= 1'b1;
            awAddr_reg <= {s_axi_awaddr[5:2], 2'h0};
         end
         if (s_axi_wvalid && !wTaken_reg && !s_axi_wready && !s_axi_bvalid)
         begin
            s_axi_wready <= 1'b1;
            wTaken_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (awTaken_reg && wTaken_reg && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_reg > `IAD_OFS_LASTADDR) ? 2'h2 : 2'h0;
            awTaken_reg <= 1'b0;
            wTaken_reg <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read channel.
   always @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
         begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[5:2], 2'h0})
               `IAD_OFS_ACCA: s_axi_rdata <= {24'h000000, accA_reg};
               `IAD_OFS_ACCB: s_axi_rdata <= {24'h000000, accB_reg};
               `IAD_OFS_DACC: s_axi_rdata <= {16'h0000, dAcc};
               `IAD_OFS_INDEX1: s_axi_rdata <= {16'h0000, index1_reg};
               `IAD_OFS_INDEX2: s_axi_rdata <= {16'h0000, index2_reg};
               `IAD_OFS_SP: s_axi_rdata <= {16'h0000, sp_reg};
               `IAD_OFS_PC: s_axi_rdata <= {16'h0000, pc_reg};
               `IAD_OFS_FLAGS: s_axi_rdata <= {24'h000000, flags_reg};
               `IAD_OFS_CTRL: s_axi_rdata <= {31'h0000000, ctrlEnable_reg};
               `IAD_OFS_STATUS: s_axi_rdata <= {28'h0000000, lastMode_reg,
                  illegalSticky_reg, state_reg != ST_IDLE};
               `IAD_OFS_LASTADDR: s_axi_rdata <= {16'h0000, lastAddr_reg};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ==== verification/iad_indexed_address_decoder_sva.sv ====
`timescale 1ns/1ps
module iad_indexed_address_decoder_sva
(
   input wire logic clk, // Clock.
   input wire logic nrst, // Reset.
   input wire logic qValid, // Queue valid.
   input wire logic [7:0] qByte0, // Byte 0.
   input wire logic [7:0] qByte1, // Byte 1.
   input wire logic [7:0] qByte2, // Byte 2.
   input wire logic qReady, // Bytes taken.
   input wire logic addrValid, // Address done.
   input wire logic [15:0] effAddr, // Address.
   input wire logic page2, // Second page.
   input wire logic [7:0] opcode, // Opcode.
   input wire logic memReq, // Fetch.
   input wire logic [15:0] memAddr, // Fetch address.
   input wire logic memAck, // Fetch answer.
   input wire logic [7:0] memData // Fetch byte.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic ackOdd;
   logic [7:0] hiByte;
   // Keeps the first byte of a pointer fetch so the second can be paired with it.
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         ackOdd <= 1'b0;
         hiByte <= 8'h00;
      end
      else if (!memReq)
         ackOdd <= 1'b0;
      else if (memAck)
      begin
         ackOdd <= !ackOdd;
         if (!ackOdd)
            hiByte <= memData;
      end
   sequence taken_s;
      qReady && qValid;
   endsequence
   sequence plain_s;
      taken_s ##0 qByte0 != 8'h18;
   endsequence
   qready_pulse_a: assert property (qReady |-> $past(qValid) ##1 !qReady)
      else $error("queue take is not a single pulse");
   plain_time_a: assert property (taken_s ##1 !memReq |-> ##1 addrValid)
      else $error("address late");
   direct_addr_a: assert property (plain_s ##0 qByte0[5:4] == 2'h1
      |-> ##2 addrValid && effAddr == {8'h00, $past(qByte1, 2)}) else $error("direct address");
   full_addr_a: assert property (plain_s ##0 qByte0[5:4] == 2'h3
      |-> ##3 effAddr == {$past(qByte1, 3), $past(qByte2, 3)}) else $error("full address");
   page_two_a: assert property (taken_s ##0 qByte0 == 8'h18 && qByte1[5:4] != 2'h2
      |-> ##3 page2 && opcode == $past(qByte1, 3)) else $error("second page");
   valid_pulse_a: assert property (addrValid |=> !addrValid)
      else $error("address valid too long");
   ptr_step_a: assert property (memReq && memAck && !ackOdd
      |=> memReq && memAddr == $past(memAddr) + 16'h0001) else $error("pointer step");
   ptr_word_a: assert property (memReq && memAck && ackOdd
      |-> ##2 addrValid && effAddr == {hiByte, $past(memData, 2)}) else $error("pointer word");
endmodule
bind iad_indexed_address_decoder iad_indexed_address_decoder_sva chk (
   .clk(clk), .nrst(nrst), .qValid(qValid), .qByte0(qByte0), .qByte1(qByte1), .qByte2(qByte2),
   .qReady(qReady), .addrValid(addrValid), .effAddr(effAddr), .page2(page2), .opcode(opcode),
   .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memData(memData));

// ==== verification/iad_indexed_address_decoder_test.sv ====
`timescale 1ns/1ps
module iad_indexed_address_decoder_test;
   typedef struct {logic [39:0] b; logic [15:0] ea; logic [2:0] len; logic [1:0] kind;} iad_row_t;
   logic clk, nrst = 1'b0, qValid = 1'b0, stackPush = 1'b0, stackPull = 1'b0;
   logic [39:0] q = 40'h0;
   logic [7:0] qByte0, qByte1, qByte2, qByte3, qByte4, opcode, memData;
   logic qReady, addrValid, page2, illegal, memReq, memAck;
   logic [15:0] effAddr, memAddr, pc, expAddr;
   logic [2:0] instrLen;
   logic [3:0] waitCycles = 4'h0;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int failCount = 0;
   int checks = 0;
   iad_row_t rows[22] = '{'{40'h967F000000, 16'h007F, 3'h2, 2'h0},
      '{40'hB6ABCD0000, 16'hABCD, 3'h3, 2'h0}, '{40'h86F0000000, 16'hFFF0, 3'h2, 2'h1},
      '{40'h1886123400, 16'h1234, 3'h4, 2'h1}, '{40'hA60F000000, 16'h100F, 3'h2, 2'h0},
      '{40'h18A60F0000, 16'h100F, 3'h3, 2'h0}, '{40'hA650000000, 16'h1FF0, 3'h2, 2'h0},
      '{40'hA69F000000, 16'h2FFF, 3'h2, 2'h0}, '{40'hA6C1000000, 16'h0001, 3'h2, 2'h1},
      '{40'hA6E1000000, 16'h0F00, 3'h3, 2'h0}, '{40'hA6E8FF0000, 16'h20FF, 3'h3, 2'h0},
      '{40'hA6F2800000, 16'hB000, 3'h4, 2'h0}, '{40'hA6E4000000, 16'h1092, 3'h2, 2'h0},
      '{40'hA6ED000000, 16'h20B4, 3'h2, 2'h0}, '{40'hA6F6000000, 16'hC2B4, 3'h2, 2'h0},
      '{40'hA6FC000000, 16'h0092, 3'h2, 2'h1}, '{40'hA6E3010000, 16'h1100, 3'h4, 2'h2},
      '{40'hA6EF000000, 16'hB2B4, 3'h2, 2'h2}, '{40'hA620000000, 16'h1001, 3'h2, 2'h0},
      '{40'hA678000000, 16'h2000, 3'h2, 2'h0}, '{40'hA6AF000000, 16'h2FFF, 3'h2, 2'h0},
      '{40'hA637000000, 16'h1001, 3'h2, 2'h0}};
   assign {qByte0, qByte1, qByte2, qByte3, qByte4} = q;
   iad_indexed_address_decoder dut (.clk(clk), .nrst(nrst), .qValid(qValid), .qByte0(qByte0),
      .qByte1(qByte1), .qByte2(qByte2), .qByte3(qByte3), .qByte4(qByte4), .qReady(qReady),
      .addrValid(addrValid), .effAddr(effAddr), .instrLen(instrLen), .page2(page2),
      .opcode(opcode), .illegal(illegal), .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
      .memData(memData), .stackPush(stackPush), .stackPull(stackPull),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   iad_mem_model mem (.clk(clk), .nrst(nrst), .memReq(memReq), .memAddr(memAddr),
      .waitCycles(waitCycles), .memAck(memAck), .memData(memData));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [7:0] memByte(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   task automatic conclude;
      if (failCount == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic waitEdge(inout int n);
      @(posedge clk);
      n++;
      if (n > 80)
      begin
         failCount++;
         conclude();
      end
   endtask
   task automatic doReset;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic axiWrite(input logic [5:0] a, input logic [31:0] d, input logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         waitEdge(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, resp);
   endtask
   task automatic axiRead(input logic [5:0] a, input logic [31:0] d, input logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         waitEdge(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, resp);
   endtask
   task automatic decode(input logic [39:0] b);
      int n;
      n = 0;
      @(posedge clk);
      q <= b;
      qValid <= 1'b1;
      do
         waitEdge(n);
      while (qReady !== 1'b1);
      qValid <= 1'b0;
      q <= ~b;
      do
         waitEdge(n);
      while (addrValid !== 1'b1);
   endtask
   initial
   begin
      doReset();
      axiWrite(6'h20, 32'h1, 2'h0);
      axiWrite(6'h00, 32'h92, 2'h0);
      axiWrite(6'h04, 32'hB4, 2'h0);
      axiRead(6'h08, 32'h92B4, 2'h0);
      axiWrite(6'h0C, 32'h1000, 2'h0);
      axiWrite(6'h10, 32'h2000, 2'h0);
      axiWrite(6'h14, 32'h3000, 2'h0);
      axiWrite(6'h18, 32'h4000, 2'h0);
      axiWrite(6'h2C, 32'h5555, 2'h2);
      pc = 16'h4000;
      foreach (rows[i])
      begin
         waitCycles <= 4'(i % 5);
         decode(rows[i].b);
         pc = pc + 16'(rows[i].len);
         expAddr = rows[i].ea + (rows[i].kind == 2'h1 ? pc : 16'h0000);
         if (rows[i].kind == 2'h2)
            expAddr = {memByte(expAddr), memByte(expAddr + 16'h0001)};
         chk(effAddr, expAddr);
         chk(instrLen, rows[i].len);
         chk(page2, rows[i].b[39:32] == 8'h18);
         chk(opcode, rows[i].b[39:32] == 8'h18 ? rows[i].b[31:24] : rows[i].b[39:32]);
         chk(illegal, 1'b0);
      end
      axiRead(6'h0C, 32'h1009, 2'h0);
      axiRead(6'h10, 32'h1FF8, 2'h0);
      axiRead(6'h18, 32'(pc), 2'h0);
      axiRead(6'h28, 32'h1001, 2'h0);
      axiRead(6'h24, 32'h8, 2'h0);
      @(posedge clk);
      stackPush <= 1'b1;
      @(posedge clk);
      stackPush <= 1'b0;
      axiRead(6'h14, 32'h2FFD, 2'h0);
      stackPull <= 1'b1;
      @(posedge clk);
      stackPull <= 1'b0;
      axiRead(6'h14, 32'h2FFF, 2'h0);
      doReset();
      axiRead(6'h1C, 32'hD0, 2'h0);
      axiRead(6'h14, 32'h0, 2'h0);
      axiRead(6'h20, 32'h0, 2'h0);
      axiRead(6'h2C, 32'h0, 2'h2);
      q <= 40'hA60F000000;
      qValid <= 1'b1;
      repeat (6) @(posedge clk) chk(qReady, 1'b0);
      qValid <= 1'b0;
      conclude();
   end
endmodule

// ==== verification/iad_mem_model.sv ====
`timescale 1ns/1ps
module iad_mem_model
(
   input wire logic clk, // Clock.
   input wire logic nrst, // Reset.
   input wire logic memReq, // Fetch request.
   input wire logic [15:0] memAddr, // Fetch address.
   input wire logic [3:0] waitCycles, // Answer delay.
   output logic memAck, // Byte ready.
   output logic [7:0] memData // Byte.
);
   logic [3:0] waitCount;
   // Between answers the data toggles so a stale byte never passes for a fresh one.
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         memAck <= 1'b0;
         memData <= 8'hA5;
         waitCount <= 4'h0;
      end
      else if (memReq && !memAck && waitCount >= waitCycles)
      begin
         memAck <= 1'b1;
         memData <= memAddr[7:0] ^ memAddr[15:8] ^ 8'h5A;
         waitCount <= 4'h0;
      end
      else
      begin
         memAck <= 1'b0;
         memData <= ~memData;
         if (memReq && !memAck)
            waitCount <= waitCount + 4'h1;
      end
endmodule
